// ### logic/lcrg_regs.sv
// International control register bank with hook release timing and interrupts
// Behaviour
// [R1] Release time from speed, extension, quench bits
// [R2] Release timed from hook clear to zero current
// [R3] Filter bit picks FIR or IIR both paths
// [R4] Impedance bit picks high or synthesized ringer
// [R5] Threshold pair picks level; 01 forbidden
// [R6] Reserved bits 7,5 writable, no effect
// [R7] Reduced variant: software writes extension threshold zero
// [R8] Calibration clear erases data until rewritten
// [R9] Manual calibration bit written one starts calibration
// [R10] Autocal disable bit suppresses automatic calibration
// [R11] Overload protect bit enables protection; clear before offhook
// [R12] Billing enable holds hook, sets detect flag
// [R13] Writing billing enable zero clears flag
// [R14] Receive overload flag; writing zero clears both flags
`timescale 1ns/100ps
module lcrg_regs #(
  parameter int CNT_W          = 32,
  parameter int P_FAST_CYC     = lcrg_pkg::RELEASE_FAST_CYC,
  parameter int P_ETSI_CYC     = lcrg_pkg::RELEASE_ETSI_CYC,
  parameter int P_SPARK_CYC    = lcrg_pkg::RELEASE_SPARK_CYC
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  input  wire lcrg_pkg::lcrg_avs_req_type i_avs,
  output logic                            o_avs_waitrequest,
  output logic [31:0]                     o_avs_readdata,
  input  wire logic                       i_supply_disrupt,
  input  wire logic                       i_rx_below_ground,
  output lcrg_pkg::lcrg_ctrl_type         o_ctrl,
  output logic                            o_adc_cal_start,
  output logic                            o_line_offhook,
  output logic                            o_irq
);
  import lcrg_pkg::*;

  // Pick the release interval from the three speed controls
  function automatic logic [CNT_W-1:0] f_release_cycles(
    input logic       speed,
    input logic       ext,
    input logic [1:0] quench
  );
    logic [CNT_W-1:0] cyc;
    // Other combinations release fast
    cyc = CNT_W'(P_FAST_CYC);
    if (speed && quench == QUENCH_SPARK) begin
      cyc = CNT_W'(P_SPARK_CYC);
    end else if (!speed && ext && quench == QUENCH_NONE) begin
      cyc = CNT_W'(P_ETSI_CYC);
    end
    return cyc;
  endfunction

  // Write-one-to-clear merge where a fresh event outranks the clear
  function automatic logic [2:0] f_w1c(
    input logic [2:0] cur,
    input logic [2:0] clr,
    input logic [2:0] set
  );
    // Set last, so a same-cycle event survives
    return (cur & ~clr) | set;
  endfunction

  // Stored register bits
  logic        onhook_speed_sel_ff;       // Release speed select
  logic        recursive_filter_sel_ff;   // IIR when set
  logic        ringer_impedance_sel_ff;   // Synthesized ringer when set
  logic        ring_threshold_sel_ff;     // Threshold low bit
  logic        adc_cal_clear_ff;          // Calibration data held clear
  logic        adc_cal_manual_ff;         // Last manual request value
  logic        adc_autocal_dis_ff;        // Automatic calibration off
  logic        ring_threshold_ext_ff;     // Threshold extension bit
  logic        overload_protect_ff;       // Overload protection on
  logic        billing_tone_en_ff;        // Ride-through enabled
  logic        rx_overload_flag_ff;       // Receive below ground seen
  logic        billing_tone_flag_ff;      // Supply disruption seen while ride-through enabled
  logic        line_hook_ctrl_ff;         // Software off-hook request
  logic        speed_ext_ff;              // Release speed extension
  logic [1:0]  quench_ff;                 // Spark quench field
  logic [2:0]  irq_status_ff;             // Sticky event bits
  logic [2:0]  irq_mask_ff;               // Interrupt enables
  logic        ack_ff;                    // Bus answer phase
  logic [31:0] rdata_ff;                  // Registered read data
  logic        cal_start_ff;              // Manual calibration pulse
  logic        offhook_ff;                // Hook drive to line
  logic        irq_ff;                    // Registered interrupt
  lcrg_ring_lvl_type ring_lvl_ff;         // Decoded detect level
  logic        rx_ovl_prev_ff;            // For rising-edge detect
  logic        disrupt_prev_ff;           // For rising-edge detect

  // Synchronised line-side levels
  logic        disrupt_sync;
  logic        rx_below_sync;

  // Line-side inputs arrive from another domain
  // Independent levels sharing one stage pair
  lcrg_sync2 #(
    .W (2)
  ) u_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   ({i_supply_disrupt, i_rx_below_ground}),
    .o_q   ({disrupt_sync, rx_below_sync})
  );

  // Bus decode: request held until the answer phase
  wire         req_any    = i_avs.read || i_avs.write;
  wire  [5:0]  word_idx   = i_avs.address[7:2];
  wire         wr_fire    = i_avs.write && ack_ff && i_avs.byteenable[0];
  wire  [7:0]  wdat       = i_avs.writedata[7:0];
  wire         wr_one     = wr_fire && word_idx == IDX_INTL_ONE;
  wire         wr_two     = wr_fire && word_idx == IDX_INTL_TWO;
  wire         wr_hook    = wr_fire && word_idx == IDX_HOOK_CTRL;
  wire         wr_status  = wr_fire && word_idx == IDX_IRQ_STATUS;
  wire         wr_mask    = wr_fire && word_idx == IDX_IRQ_MASK;

  // Events from the line side
  wire         rx_ovl_evt  = rx_below_sync && !rx_ovl_prev_ff;
  wire         disrupt_evt = disrupt_sync && !disrupt_prev_ff;
  wire         billing_evt = disrupt_evt && billing_tone_en_ff;                // [R12]
  wire         release_done;
  wire         release_busy;

  // Clearing the hook bit starts the release interval
  wire         hook_release = wr_hook && !wdat[POS_HOOK] && line_hook_ctrl_ff; // [R2]
  wire [CNT_W-1:0] release_load = f_release_cycles(onhook_speed_sel_ff,        // [R1]
                                                   speed_ext_ff, quench_ff);

  // Release interval counter
  lcrg_onhook_timer #(
    .CNT_W (CNT_W)
  ) u_timer (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_start (hook_release),
    .i_load  (release_load),
    .o_busy  (release_busy),
    .o_done  (release_done)
  );

  // Read-back images of each register
  // Read data captured in a read's first cycle
  wire  [7:0]  rd_one  = {1'b0, onhook_speed_sel_ff, 1'b0, recursive_filter_sel_ff,
                          2'b00, ringer_impedance_sel_ff, ring_threshold_sel_ff};
  wire  [7:0]  rd_two  = {adc_cal_clear_ff, adc_cal_manual_ff, adc_autocal_dis_ff,
                          ring_threshold_ext_ff, overload_protect_ff, billing_tone_en_ff,
                          rx_overload_flag_ff, billing_tone_flag_ff};
  wire  [7:0]  rd_hook = {3'b000, release_busy, quench_ff, speed_ext_ff, line_hook_ctrl_ff};
  wire  [7:0]  rd_mux  = (word_idx == IDX_INTL_ONE)   ? rd_one :
                         (word_idx == IDX_INTL_TWO)   ? rd_two :
                         (word_idx == IDX_HOOK_CTRL)  ? rd_hook :
                         (word_idx == IDX_IRQ_STATUS) ? {5'b00000, irq_status_ff} :
                         (word_idx == IDX_IRQ_MASK)   ? {5'b00000, irq_mask_ff} :
                         8'h00;                       // Unmapped reads zero

  // Interrupt status next value
  wire  [2:0]  irq_set   = {release_done, rx_ovl_evt, billing_evt};
  wire  [2:0]  irq_w1c   = wr_status ? wdat[2:0] : 3'b000;
  wire         rx_clr_wr = wr_two && !wdat[POS_RX_OVL_FLAG];                   // [R14]
  wire  [2:0]  irq_clr   = irq_w1c | {1'b0, rx_clr_wr, 1'b0};                  // [R14]
  wire  [2:0]  nxt_irq_status = f_w1c(irq_status_ff, irq_clr, irq_set);

  // Threshold pair decode; forbidden 01 falls back to the lowest level
  // Fed by next values so it moves with o_ctrl
  wire         nxt_thr_lo  = wr_one ? wdat[POS_RING_THRESH] : ring_threshold_sel_ff;
  wire         nxt_thr_ext = wr_two ? wdat[POS_RING_THR_EXT] : ring_threshold_ext_ff;
  wire  [1:0]  thr_pair = {nxt_thr_lo, nxt_thr_ext};
  lcrg_ring_lvl_type nxt_ring_lvl;
  assign nxt_ring_lvl = (thr_pair == 2'b11) ? RING_LVL_40V5 :                  // [R5]
                        (thr_pair == 2'b10) ? RING_LVL_19V35 :
                        RING_LVL_13V5;

  // Without ride-through a supply dip drops the hook drive
  wire         nxt_offhook = (line_hook_ctrl_ff || release_busy) &&           // [R2]
                             !(disrupt_sync && !billing_tone_en_ff);           // [R12]

  // Bus answer: one wait cycle, then the transfer completes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      // Ack lasts one cycle; held requests wait again
      ack_ff   <= req_any && !ack_ff;
      rdata_ff <= (i_avs.read && !ack_ff) ? {24'h00_0000, rd_mux} : rdata_ff;
    end
  end

  // First control register; bits 7 and 5 are dropped on write
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      // Reserved bits are not stored
      onhook_speed_sel_ff     <= RST_INTL_ONE[POS_ONHOOK_SPEED];
      recursive_filter_sel_ff <= RST_INTL_ONE[POS_RECURSIVE_FLT];
      ringer_impedance_sel_ff <= RST_INTL_ONE[POS_RINGER_IMP];
      ring_threshold_sel_ff   <= RST_INTL_ONE[POS_RING_THRESH];
    end else if (wr_one) begin                                                 // [R6]
      onhook_speed_sel_ff     <= wdat[POS_ONHOOK_SPEED];                       // [R1]
      recursive_filter_sel_ff <= wdat[POS_RECURSIVE_FLT];                      // [R3]
      ringer_impedance_sel_ff <= wdat[POS_RINGER_IMP];                         // [R4]
      ring_threshold_sel_ff   <= wdat[POS_RING_THRESH];                        // [R5]
    end
  end

  // Second control register writable fields
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      adc_cal_clear_ff      <= RST_INTL_TWO[POS_CAL_CLEAR];
      adc_cal_manual_ff     <= RST_INTL_TWO[POS_CAL_MANUAL];
      adc_autocal_dis_ff    <= RST_INTL_TWO[POS_AUTOCAL_DIS];
      ring_threshold_ext_ff <= RST_INTL_TWO[POS_RING_THR_EXT];
      overload_protect_ff   <= RST_INTL_TWO[POS_OVL_PROTECT];
      billing_tone_en_ff    <= RST_INTL_TWO[POS_BILLING_EN];
    end else if (wr_two) begin
      adc_cal_clear_ff      <= wdat[POS_CAL_CLEAR];                            // [R8]
      adc_cal_manual_ff     <= wdat[POS_CAL_MANUAL];                           // [R9]
      adc_autocal_dis_ff    <= wdat[POS_AUTOCAL_DIS];                          // [R10]
      ring_threshold_ext_ff <= wdat[POS_RING_THR_EXT];                         // [R7]
      overload_protect_ff   <= wdat[POS_OVL_PROTECT];                          // [R11]
      billing_tone_en_ff    <= wdat[POS_BILLING_EN];                           // [R12]
    end
  end

  // Hardware flags; a new event outranks a same-cycle clear
  // Writing one to a flag does nothing
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_overload_flag_ff  <= RST_INTL_TWO[POS_RX_OVL_FLAG];
      billing_tone_flag_ff <= RST_INTL_TWO[POS_BILLING_FLAG];
    end else begin
      rx_overload_flag_ff  <= rx_ovl_evt || (rx_overload_flag_ff && !rx_clr_wr);  // [R14]
      billing_tone_flag_ff <= billing_evt ||                                      // [R12]
                              (billing_tone_flag_ff &&
                               !(wr_two && !wdat[POS_BILLING_EN]));               // [R13]
    end
  end

  // Hook control and speed extension fields
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      {quench_ff, speed_ext_ff, line_hook_ctrl_ff} <= RST_HOOK_CTRL;
    end else if (wr_hook) begin
      // Clearing the hook starts the timer
      line_hook_ctrl_ff <= wdat[POS_HOOK];
      speed_ext_ff      <= wdat[POS_SPEED_EXT];                                // [R1]
      quench_ff         <= wdat[POS_QUENCH_LO +: 2];                           // [R1]
    end
  end

  // Interrupt status and mask
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_status_ff <= RST_IRQ;
      irq_mask_ff   <= RST_IRQ;
    end else begin
      // Mask writes leave sticky bits alone
      irq_status_ff <= nxt_irq_status;
      irq_mask_ff   <= wr_mask ? wdat[2:0] : irq_mask_ff;
    end
  end

  // Registered outputs and edge history
  // Edge history resets to the pins' idle low level
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cal_start_ff    <= 1'b0;
      offhook_ff      <= 1'b0;
      irq_ff          <= 1'b0;
      ring_lvl_ff     <= RING_LVL_13V5;
      rx_ovl_prev_ff  <= 1'b0;
      disrupt_prev_ff <= 1'b0;
    end else begin
      cal_start_ff    <= wr_two && wdat[POS_CAL_MANUAL];                       // [R9]
      offhook_ff      <= nxt_offhook;
      // Rises with the sticky bit, not after it
      irq_ff          <= |(nxt_irq_status & irq_mask_ff);
      ring_lvl_ff     <= nxt_ring_lvl;                                         // [R5]
      rx_ovl_prev_ff  <= rx_below_sync;
      disrupt_prev_ff <= disrupt_sync;
    end
  end

  // Handshake is combinational; data outputs come from flops
  assign o_avs_waitrequest = req_any && !ack_ff;
  assign o_avs_readdata    = rdata_ff;
  assign o_adc_cal_start   = cal_start_ff;
  assign o_line_offhook    = offhook_ff;
  assign o_irq             = irq_ff;

  // Configuration toward the line interface
  // Autocal stored as a disable, driven as an enable
  assign o_ctrl.recursive_filter_select = recursive_filter_sel_ff;             // [R3]
  assign o_ctrl.ringer_impedance_sel    = ringer_impedance_sel_ff;             // [R4]
  assign o_ctrl.ring_level              = ring_lvl_ff;
  assign o_ctrl.adc_cal_clear           = adc_cal_clear_ff;                    // [R8]
  assign o_ctrl.adc_autocal_en          = !adc_autocal_dis_ff;                 // [R10]
  assign o_ctrl.overload_protect_en     = overload_protect_ff;                 // [R11]
  assign o_ctrl.billing_tone_en         = billing_tone_en_ff;

endmodule // lcrg_regs

// ### logic/lcrg_pkg.sv
// Shared constants and types of the line interface control register bank
package lcrg_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_INTL_ONE   = 6'h10;
  localparam logic [5:0] IDX_INTL_TWO   = 6'h11;
  localparam logic [5:0] IDX_HOOK_CTRL  = 6'h20;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h21;
  localparam logic [5:0] IDX_IRQ_MASK   = 6'h22;

  // Reset values
  localparam logic [7:0] RST_INTL_ONE   = 8'h00;
  localparam logic [7:0] RST_INTL_TWO   = 8'h00;
  localparam logic [3:0] RST_HOOK_CTRL  = 4'h0;
  localparam logic [2:0] RST_IRQ        = 3'h0;

  // First control register field positions
  localparam int POS_ONHOOK_SPEED  = 6;
  localparam int POS_RECURSIVE_FLT = 4;
  localparam int POS_RINGER_IMP    = 1;
  localparam int POS_RING_THRESH   = 0;

  // Second control register field positions
  localparam int POS_CAL_CLEAR     = 7;
  localparam int POS_CAL_MANUAL    = 6;
  localparam int POS_AUTOCAL_DIS   = 5;
  localparam int POS_RING_THR_EXT  = 4;
  localparam int POS_OVL_PROTECT   = 3;
  localparam int POS_BILLING_EN    = 2;
  localparam int POS_RX_OVL_FLAG   = 1;
  localparam int POS_BILLING_FLAG  = 0;

  // Hook control register field positions
  localparam int POS_HOOK          = 0;
  localparam int POS_SPEED_EXT     = 1;
  localparam int POS_QUENCH_LO     = 2;
  localparam int POS_RELEASE_BUSY  = 4;

  // Interrupt status / mask bit positions
  localparam int IRQ_BILLING       = 0;
  localparam int IRQ_RX_OVL        = 1;
  localparam int IRQ_RELEASE_DONE  = 2;

  // Quench field codes
  localparam logic [1:0] QUENCH_NONE  = 2'h0;
  localparam logic [1:0] QUENCH_SPARK = 2'h3;

  // Release times in microseconds and clock rate
  localparam int CLK_MHZ          = 200;
  localparam int RELEASE_FAST_US  = 500;
  localparam int RELEASE_ETSI_US  = 3000;
  localparam int RELEASE_SPARK_US = 26000;
  // Fast release must stay under its bound, so one cycle short of it
  localparam int RELEASE_FAST_CYC  = RELEASE_FAST_US * CLK_MHZ - 1;
  localparam int RELEASE_ETSI_CYC  = RELEASE_ETSI_US * CLK_MHZ;
  localparam int RELEASE_SPARK_CYC = RELEASE_SPARK_US * CLK_MHZ;

  // Ring detect level codes
  typedef enum logic [1:0] {
    RING_LVL_13V5  = 2'b00,
    RING_LVL_19V35 = 2'b01,
    RING_LVL_40V5  = 2'b10
  } lcrg_ring_lvl_type;

  // Avalon-MM request from the master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } lcrg_avs_req_type;

  // Configuration driven toward the line interface
  typedef struct packed {
    logic              recursive_filter_select;
    logic              ringer_impedance_sel;
    lcrg_ring_lvl_type ring_level;
    logic              adc_cal_clear;
    logic              adc_autocal_en;
    logic              overload_protect_en;
    logic              billing_tone_en;
  } lcrg_ctrl_type;

endpackage

// ### logic/lcrg_sync2.sv
// Two-stage synchroniser for asynchronous line-side levels
`timescale 1ns/100ps
module lcrg_sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_ff;   // First stage, read only by second
  logic [W-1:0] sync_ff;   // Second stage, safe to use

  // Plain double flop; nothing taps the first stage
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_d;
      sync_ff <= meta_ff;
    end
  end

  assign o_q = sync_ff;
endmodule // lcrg_sync2

// ### logic/lcrg_onhook_timer.sv
// Down-counter timing the on-hook release interval
`timescale 1ns/100ps
module lcrg_onhook_timer #(
  parameter int CNT_W = 32
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_start,
  input  wire logic [CNT_W-1:0] i_load,
  output logic                  o_busy,
  output logic                  o_done
);
  logic [CNT_W-1:0] cnt_ff;    // Cycles left
  logic             busy_ff;   // Interval running
  logic             done_ff;   // One-cycle end pulse
  wire              last_cyc = busy_ff && (cnt_ff <= CNT_W'(1));

  // Start reloads even while busy, so a new release restarts timing
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (i_start) begin
      cnt_ff  <= i_load;
      busy_ff <= 1'b1;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= busy_ff ? cnt_ff - CNT_W'(1) : cnt_ff;
      busy_ff <= busy_ff && !last_cyc;
      done_ff <= last_cyc;
    end
  end

  assign o_busy = busy_ff;
  assign o_done = done_ff;
endmodule // lcrg_onhook_timer

// ### tb/lcrg_regs_sva.sv
// Assertion checker for the control register bank
`timescale 1ns/100ps
module lcrg_regs_sva
  import lcrg_pkg::*;
#(
  parameter int CNT_W       = 32,
  parameter int P_FAST_CYC  = 5,
  parameter int P_ETSI_CYC  = 20,
  parameter int P_SPARK_CYC = 40
) (
  input wire logic                       i_clk,
  input wire logic                       i_rst,
  input wire lcrg_pkg::lcrg_avs_req_type i_avs,
  input wire logic                       o_avs_waitrequest,
  input wire logic [31:0]                o_avs_readdata,
  input wire logic                       i_supply_disrupt,
  input wire logic                       i_rx_below_ground,
  input wire lcrg_pkg::lcrg_ctrl_type    o_ctrl,
  input wire logic                       o_adc_cal_start,
  input wire logic                       o_line_offhook,
  input wire logic                       o_irq
);
  import lcrg_pkg::*;
  logic [5:0] idx;     // Word index
  logic       wr_done; // Write that lands
  logic       rd_done; // Read that completes
  logic       wr_one;  // Write to first control
  logic       wr_two;  // Write to second control
  logic       cal_req; // Manual calibration request
  logic       mapped;  // Index decodes
  logic [7:0] wd_ff;   // Low data byte, one cycle late
  assign idx     = i_avs.address[7:2];
  assign wr_done = i_avs.write && !o_avs_waitrequest && i_avs.byteenable[0];
  assign rd_done = i_avs.read && !o_avs_waitrequest;
  assign wr_one  = wr_done && (idx == IDX_INTL_ONE);
  assign wr_two  = wr_done && (idx == IDX_INTL_TWO);
  assign cal_req = wr_two && i_avs.writedata[6];
  assign mapped  = idx inside {IDX_INTL_ONE, IDX_INTL_TWO, IDX_HOOK_CTRL, IDX_IRQ_STATUS, IDX_IRQ_MASK};
  // Held byte avoids $past on a slice
  always_ff @(posedge i_clk) begin
    wd_ff <= i_avs.writedata[7:0];
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Request start, then exactly one wait cycle
  sequence s_req_start;
    $rose(i_avs.read || i_avs.write);
  endsequence
  sequence s_one_wait;
    o_avs_waitrequest ##1 !o_avs_waitrequest;
  endsequence
  wait_one_a: assert property (s_req_start |-> s_one_wait)
    else $error("wait cycle count wrong");
  rsvd_zero_a: assert property (rd_done && idx == IDX_INTL_ONE |->
    (o_avs_readdata & 32'hFFFF_FFAC) == 32'h0000_0000)
    else $error("reserved bits read nonzero");
  filter_imp_a: assert property (wr_one |=>
    o_ctrl.recursive_filter_select == wd_ff[4] && o_ctrl.ringer_impedance_sel == wd_ff[1])
    else $error("filter or impedance select wrong");
  cal_fields_a: assert property (wr_two |=>
    o_ctrl.adc_cal_clear == wd_ff[7] && o_ctrl.adc_autocal_en != wd_ff[5])
    else $error("calibration controls wrong");
  prot_bill_a: assert property (wr_two |=>
    o_ctrl.overload_protect_en == wd_ff[3] && o_ctrl.billing_tone_en == wd_ff[2])
    else $error("protect or billing enable wrong");
  cal_pulse_a: assert property (o_adc_cal_start == $past(cal_req))
    else $error("calibration start pulse wrong");
  level_legal_a: assert property (o_ctrl.ring_level != 2'b11)
    else $error("ring level code illegal");
  ctrl_hold_a: assert property (!wr_done |=> $stable(o_ctrl))
    else $error("control changed without write");
  unmapped_zero_a: assert property (rd_done && !mapped |-> o_avs_readdata == 32'h0000_0000)
    else $error("unmapped read nonzero");
endmodule // lcrg_regs_sva

bind lcrg_regs lcrg_regs_sva #(.CNT_W(CNT_W), .P_FAST_CYC(P_FAST_CYC), .P_ETSI_CYC(P_ETSI_CYC),
  .P_SPARK_CYC(P_SPARK_CYC)) u_sva (.i_clk(i_clk), .i_rst(i_rst), .i_avs(i_avs),
  .o_avs_waitrequest(o_avs_waitrequest), .o_avs_readdata(o_avs_readdata),
  .i_supply_disrupt(i_supply_disrupt), .i_rx_below_ground(i_rx_below_ground), .o_ctrl(o_ctrl),
  .o_adc_cal_start(o_adc_cal_start), .o_line_offhook(o_line_offhook), .o_irq(o_irq));

// ### tb/tb.sv
// Self-checking bench for the control register bank
`timescale 1ns/100ps
module tb;
  import lcrg_pkg::*;
  logic             i_clk;     // 200 MHz clock
  logic             i_rst;     // Sync reset
  lcrg_avs_req_type avs;       // Bus request
  logic             wait_req;  // Slave stall
  logic [31:0]      rdata;     // Read data
  logic             disrupt;   // Supply disruption level
  logic             below;     // Receive below ground
  lcrg_ctrl_type    ctrl;      // Line configuration
  logic             cal_start; // Calibration pulse
  logic             offhook;   // Hook drive
  logic             irq;       // Interrupt
  int               failures;  // Mismatches
  int               n_checks;  // Comparisons
  int               seed;      // Random seed
  int               i;         // Loop index
  int               n;         // Cycle counter
  logic [31:0]      q;         // Last read word
  logic [7:0]       d;         // Random data
  logic [3:0]       rel [4];   // Release cases {speed, ext, quench}
  // Short counts keep the release tests brief
  lcrg_regs #(.P_FAST_CYC(5), .P_ETSI_CYC(20), .P_SPARK_CYC(40)) DUT (.i_clk(i_clk), .i_rst(i_rst),
    .i_avs(avs), .o_avs_waitrequest(wait_req), .o_avs_readdata(rdata), .i_supply_disrupt(disrupt),
    .i_rx_below_ground(below), .o_ctrl(ctrl), .o_adc_cal_start(cal_start), .o_line_offhook(offhook),
    .o_irq(irq));
  // Clock generator
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // One bus cycle; held until waitrequest is seen low at a rising edge
  task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] wd, input logic [3:0] be);
    @(posedge i_clk);
    avs <= '{read: rd, write: !rd, address: a, writedata: {24'h00_0000, wd}, byteenable: be};
    do begin
      @(posedge i_clk);
    end while (wait_req !== 1'b0);
    q = rdata;
    avs.read <= 1'b0;
    avs.write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    bus(1'b0, a, wd, 4'h1);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b1, a, 8'h00, 4'h0);
    check(q, exp);
  endtask
  // Expected ring level; forbidden pair falls to the lowest level
  function automatic logic [1:0] ring_exp(input logic lo, input logic ext);
    return (lo && ext) ? 2'h2 : (lo ? 2'h1 : 2'h0);
  endfunction
  // Expected release length from speed, extension, quench
  function automatic int rel_cyc(input logic [3:0] c);
    if (c[3] && c[1:0] == 2'h3) return 40;
    if (!c[3] && c[2] && c[1:0] == 2'h0) return 20;
    return 5;
  endfunction
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    test_done();
  end
  // Main sequence
  initial begin
    seed = 32'h9dda;
    failures = 0;
    n_checks = 0;
    i_rst = 1'b1;
    avs = '0;
    disrupt = 1'b0;
    below = 1'b0;
    rel = '{4'h0, 4'h4, 4'hF, 4'h7};
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd_chk(8'h40, 32'h0000_0000);
    rd_chk(8'h44, 32'h0000_0000);
    check({31'h0, ctrl.adc_autocal_en}, 32'h0000_0001);
    for (i = 0; i < 12; i++) begin
      d = 8'($random(seed));
      wr(8'h40, d);
      rd_chk(8'h40, {24'h0, d & 8'h53});
      check({30'h0, ctrl.recursive_filter_select, ctrl.ringer_impedance_sel}, {30'h0, d[4], d[1]});
    end
    bus(1'b0, 8'h40, 8'hFF, 4'h0);
    rd_chk(8'h40, {24'h0, d & 8'h53});
    wr(8'h3C, 8'hFF);
    rd_chk(8'h3C, 32'h0000_0000);
    // Every threshold pair, forbidden one included
    for (i = 0; i < 4; i++) begin
      wr(8'h40, {7'h0, i[0]});
      wr(8'h44, {3'h0, i[1], 4'h0});
      @(negedge i_clk);
      check({30'h0, ctrl.ring_level}, {30'h0, ring_exp(i[0], i[1])});
    end
    for (i = 0; i < 12; i++) begin
      d = 8'($random(seed)) & 8'hFC;
      wr(8'h44, d);
      @(negedge i_clk);
      check({28'h0, cal_start, ctrl.adc_cal_clear, ctrl.adc_autocal_en, ctrl.overload_protect_en},
            {28'h0, d[6], d[7], !d[5], d[3]});
      rd_chk(8'h44, {24'h0, d});
    end
    // Billing ride-through, flag, interrupt
    wr(8'h44, 8'h04);
    wr(8'h88, 8'h07);
    wr(8'h80, 8'h01);
    disrupt <= 1'b1;
    repeat (6) @(negedge i_clk);
    check({30'h0, offhook, irq}, 32'h0000_0003);
    rd_chk(8'h44, 32'h0000_0005);
    rd_chk(8'h84, 32'h0000_0001);
    wr(8'h44, 8'h00);
    rd_chk(8'h44, 32'h0000_0000);
    wr(8'h84, 8'h01);
    repeat (3) @(negedge i_clk);
    check({30'h0, offhook, irq}, 32'h0000_0000);
    @(posedge i_clk);
    disrupt <= 1'b0;
    // Receive overload and its clear
    below <= 1'b1;
    repeat (6) @(posedge i_clk);
    below <= 1'b0;
    rd_chk(8'h44, 32'h0000_0002);
    rd_chk(8'h84, 32'h0000_0002);
    check({31'h0, irq}, 32'h0000_0001);
    wr(8'h44, 8'h00);
    rd_chk(8'h44, 32'h0000_0000);
    rd_chk(8'h84, 32'h0000_0000);
    // Release time per speed, extension, quench setting
    for (i = 0; i < 4; i++) begin
      wr(8'h40, {1'b0, rel[i][3], 6'h00});
      wr(8'h80, {4'h0, rel[i][1:0], rel[i][2], 1'b1});
      wr(8'h80, {4'h0, rel[i][1:0], rel[i][2], 1'b0});
      n = 0;
      while (offhook === 1'b1 && n < 100) begin
        @(negedge i_clk);
        n++;
      end
      check({31'h0, n >= rel_cyc(rel[i]) - 1 && n <= rel_cyc(rel[i]) + 3}, 32'h0000_0001);
    end
    rd_chk(8'h84, 32'h0000_0004);
    test_done();
  end
endmodule // tb
